// *** shared/ofms_pkg.sv ***
// constants, types and helpers for output function and monitor select
package ofms_pkg;

	localparam int CODE_W = 7;
	localparam int NUM_HW = 3;
	localparam int NUM_VIRT = 16;
	localparam int NUM_LINES = 19;
	localparam int FVEC_W = 128;
	localparam int ADDR_W = 8;
	localparam int DATA_W = 32;

	// register byte addresses
	localparam logic [7:0] ADDR_ANALOG_MONITOR_ONE_SEL = 8'h00;
	localparam logic [7:0] ADDR_MON2_SEL = 8'h04;
	localparam logic [7:0] ADDR_ANALOG_MONITOR_ONE_SCALE = 8'h08;
	localparam logic [7:0] ADDR_ANALOG_MONITOR_ONE_OFS = 8'h0C;
	localparam logic [7:0] ADDR_MON2_SCALE = 8'h10;
	localparam logic [7:0] ADDR_MON2_OFS = 8'h14;
	localparam logic [7:0] ADDR_FORMAT = 8'h18;
	localparam logic [7:0] ADDR_STATUS = 8'h1C;
	localparam logic [7:0] ADDR_MASK = 8'h20;
	localparam logic [7:0] ADDR_OUT_STATE = 8'h24;
	localparam logic [7:0] ADDR_CODE_BASE = 8'h40;
	localparam logic [7:0] ADDR_CODE_LAST = 8'h88;

	// code register fields: pending low, active from this bit
	localparam int ACT_FIELD_LSB = 8;

	// output line reset codes
	localparam logic [6:0] HW1_CODE_RST = 7'h01;
	localparam logic [6:0] HW2_CODE_RST = 7'h02;
	localparam logic [6:0] HW3_CODE_RST = 7'h4C;
	localparam logic [6:0] VIRT_CODE_RST = 7'h00;

	// function codes with dedicated sources
	localparam logic [6:0] FC_IN_POSITION = 7'h02;
	localparam logic [6:0] FC_POINT_AREA1 = 7'h11;
	localparam logic [6:0] FC_POINT_AREA2 = 7'h12;
	localparam logic [6:0] FC_POS_OT = 7'h26;
	localparam logic [6:0] FC_NEG_OT = 7'h27;
	localparam logic [6:0] FC_HOME_LS = 7'h28;
	localparam logic [6:0] FC_IMM_CONT_PERMIT = 7'h4F;
	localparam logic [6:0] FC_IMM_CONT_DONE = 7'h50;
	localparam logic [6:0] FC_IMM_CHANGE_DONE = 7'h51;

	// monitor settings
	localparam int MON_SEL_W = 5;
	localparam logic [4:0] MON_SEL_MIN = 5'h01;
	localparam logic [4:0] MON_SEL_MAX = 5'h10;
	localparam logic [4:0] ANALOG_MONITOR_ONE_SEL_RST = 5'h02;
	localparam logic [4:0] MON2_SEL_RST = 5'h03;
	localparam int SCALE_W = 16;
	localparam logic [15:0] ANALOG_MONITOR_ONE_SCALE_RST = 16'h0046;
	localparam logic [15:0] MON2_SCALE_RST = 16'h003C;
	localparam logic [15:0] SCALE_MIN_MAG = 16'h0014;
	localparam logic [15:0] SCALE_MAX_MAG = 16'h03E8;
	localparam int OFS_W = 8;
	localparam logic signed [7:0] OFS_MIN = 8'hCE;
	localparam logic signed [7:0] OFS_MAX = 8'h32;
	localparam logic [7:0] OFS_RST = 8'h00;
	localparam int FMT_W = 2;
	localparam logic [1:0] FMT_RST = 2'h0;
	localparam int FMT_CH1_SINGLE = 0;
	localparam int FMT_CH2_SINGLE = 1;

	// interrupt status bits
	localparam int STAT_W = 3;
	localparam int STAT_BAD_VALUE = 0;
	localparam int STAT_BAD_SOURCE = 1;
	localparam int STAT_HW_CHANGE = 2;
	localparam logic [2:0] STAT_RST = 3'h0;

	localparam logic [1:0] RESP_OKAY = 2'h0;
	localparam logic [1:0] RESP_SLVERR = 2'h2;
	localparam logic [1:0] RESP_DECERR = 2'h3;

	typedef enum logic [1:0] {
		WS_COLLECT = 2'b01,
		WS_RESP = 2'b10
	} ofms_wr_e;

	// codes that name a status function
	function automatic logic code_legal(input logic [6:0] c);
		return c inside {7'h01, 7'h02, 7'h0B, 7'h0D, 7'h0E, [7'h10:7'h24], [7'h26:7'h29], 7'h2D, 7'h2E,
			[7'h3C:7'h43], 7'h4B, 7'h4C, [7'h4F:7'h55], [7'h5B:7'h5F]};
	endfunction

	// reset code of output line i
	function automatic logic [6:0] code_rst(input int i);
		return (i == 0) ? HW1_CODE_RST : (i == 1) ? HW2_CODE_RST : (i == 2) ? HW3_CODE_RST : VIRT_CODE_RST;
	endfunction

	// byte-lane merge of a write into a word
	function automatic logic [31:0] lane_merge(input logic [31:0] old, input logic [31:0] nw, input logic [3:0] strb);
		logic [31:0] r;
		r = old;
		for (int b = 0; b < 4; b++) begin
			if (strb[b]) begin
				r[b*8 +: 8] = nw[b*8 +: 8];
			end
		end
		return r;
	endfunction

endpackage

// *** rtl/ofms_func_mux.sv ***
// one output line: picks a status function by its code
`timescale 1ns/100ps
`default_nettype none
module ofms_func_mux import ofms_pkg::*; (
	// selection
	input wire logic [CODE_W-1:0] code,
	input wire logic [FVEC_W-1:0] fvec,
	// result
	output logic line_val
);

	always_comb begin
		if (code_legal(code)) begin
			line_val = fvec[code];
		end else begin
			line_val = 1'b0;
		end
	end

endmodule
`default_nettype wire

// *** rtl/ofms_top.sv ***
// output function routing and analog monitor selection with axi4-lite registers
`timescale 1ns/100ps
`default_nettype none
module ofms_top import ofms_pkg::*; (
	// clock and reset
	input wire logic ref_clk,
	input wire logic rst_n,
	// axi4-lite write
	input wire logic [ADDR_W-1:0] s_axi_awaddr,
	input wire logic s_axi_awvalid,
	output logic s_axi_awready,
	input wire logic [DATA_W-1:0] s_axi_wdata,
	input wire logic [3:0] s_axi_wstrb,
	input wire logic s_axi_wvalid,
	output logic s_axi_wready,
	output logic [1:0] s_axi_bresp,
	output logic s_axi_bvalid,
	input wire logic s_axi_bready,
	// axi4-lite read
	input wire logic [ADDR_W-1:0] s_axi_araddr,
	input wire logic s_axi_arvalid,
	output logic s_axi_arready,
	output logic [DATA_W-1:0] s_axi_rdata,
	output logic [1:0] s_axi_rresp,
	output logic s_axi_rvalid,
	input wire logic s_axi_rready,
	// system control
	input wire logic power_restart,
	input wire logic serial_link_src,
	// internal status functions
	input wire logic [FVEC_W-1:0] gen_status,
	input wire logic in_position_flag,
	input wire logic point_area_one,
	input wire logic point_area_two,
	input wire logic positive_overtravel,
	input wire logic negative_overtravel,
	input wire logic home_limit_detect,
	input wire logic imm_cont_permit,
	input wire logic imm_cont_done,
	input wire logic imm_change_done,
	// output lines
	output logic hw_output_line_one,
	output logic hw_output_line_two,
	output logic hw_output_line_three,
	output logic [NUM_VIRT-1:0] virt_out,
	// analog monitor settings
	output logic [MON_SEL_W-1:0] analog_monitor_one_sel,
	output logic [SCALE_W-1:0] analog_monitor_one_scale,
	output logic [OFS_W-1:0] analog_monitor_one_offset,
	output logic analog_monitor_one_invert,
	output logic analog_monitor_one_single,
	output logic [MON_SEL_W-1:0] analog_monitor_two_sel,
	output logic [SCALE_W-1:0] mon2_scale,
	output logic [OFS_W-1:0] mon2_offset,
	output logic mon2_invert,
	output logic mon2_single,
	// interrupt
	output logic irq
);

	ofms_wr_e wr_state;
	logic aw_held, w_held;
	logic [ADDR_W-1:0] aw_addr;
	logic [DATA_W-1:0] w_data;
	logic [3:0] w_strb;
	logic [CODE_W-1:0] pend_code [NUM_LINES];
	logic [CODE_W-1:0] act_code [NUM_LINES];
	logic [NUM_LINES-1:0] line_q, next_line;
	logic [FVEC_W-1:0] fvec;
	logic [FMT_W-1:0] mon_format;
	logic [STAT_W-1:0] status, mask, next_status;
	logic wr_fire, is_code, is_virt, bad_val, bad_src, unmapped;
	logic [4:0] code_idx;
	logic [DATA_W-1:0] merged;

	// register view shared by read and write merge
	function automatic logic [DATA_W-1:0] reg_view(input logic [ADDR_W-1:0] a);
		logic [ADDR_W-1:0] off;
		logic [DATA_W-1:0] v;
		off = a - ADDR_CODE_BASE;
		v = '0;
		if (a == ADDR_ANALOG_MONITOR_ONE_SEL) begin
			v[MON_SEL_W-1:0] = analog_monitor_one_sel;
		end else if (a == ADDR_MON2_SEL) begin
			v[MON_SEL_W-1:0] = analog_monitor_two_sel;
		end else if (a == ADDR_ANALOG_MONITOR_ONE_SCALE) begin
			v[SCALE_W-1:0] = analog_monitor_one_scale;
		end else if (a == ADDR_ANALOG_MONITOR_ONE_OFS) begin
			v[OFS_W-1:0] = analog_monitor_one_offset;
		end else if (a == ADDR_MON2_SCALE) begin
			v[SCALE_W-1:0] = mon2_scale;
		end else if (a == ADDR_MON2_OFS) begin
			v[OFS_W-1:0] = mon2_offset;
		end else if (a == ADDR_FORMAT) begin
			v[FMT_W-1:0] = mon_format;
		end else if (a == ADDR_STATUS) begin
			v[STAT_W-1:0] = status;
		end else if (a == ADDR_MASK) begin
			v[STAT_W-1:0] = mask;
		end else if (a == ADDR_OUT_STATE) begin
			v[NUM_LINES-1:0] = line_q;
		end else if (a >= ADDR_CODE_BASE && a <= ADDR_CODE_LAST && a[1:0] == 2'b00) begin
			v[CODE_W-1:0] = pend_code[off[6:2]];
			v[ACT_FIELD_LSB +: CODE_W] = act_code[off[6:2]];
		end
		return v;
	endfunction

	// whether an address names a register
	function automatic logic addr_mapped(input logic [ADDR_W-1:0] a);
		return (a[1:0] == 2'b00) && (a <= ADDR_OUT_STATE || (a >= ADDR_CODE_BASE && a <= ADDR_CODE_LAST));
	endfunction

	// write decode and value checks
	always_comb begin
		logic [ADDR_W-1:0] off;
		logic [SCALE_W-1:0] mag;
		logic signed [OFS_W-1:0] ofs;
		off = aw_addr - ADDR_CODE_BASE;
		mag = '0;
		ofs = '0;
		code_idx = off[6:2];
		wr_fire = (wr_state == WS_COLLECT) && aw_held && w_held;
		merged = lane_merge(reg_view(aw_addr), w_data, w_strb);
		mag = merged[SCALE_W-1] ? SCALE_W'(-merged[SCALE_W-1:0]) : merged[SCALE_W-1:0];
		ofs = merged[OFS_W-1:0];
		unmapped = !addr_mapped(aw_addr);
		is_code = !unmapped && aw_addr >= ADDR_CODE_BASE;
		is_virt = is_code && code_idx >= 5'(NUM_HW);
		bad_val = 1'b0;
		if (is_code) begin
			bad_val = !(merged[CODE_W-1:0] == 7'h00 || code_legal(merged[CODE_W-1:0]));
		end else if (aw_addr == ADDR_ANALOG_MONITOR_ONE_SEL || aw_addr == ADDR_MON2_SEL) begin
			bad_val = merged[MON_SEL_W-1:0] < MON_SEL_MIN || merged[MON_SEL_W-1:0] > MON_SEL_MAX;
		end else if (aw_addr == ADDR_ANALOG_MONITOR_ONE_SCALE || aw_addr == ADDR_MON2_SCALE) begin
			bad_val = mag < SCALE_MIN_MAG || mag > SCALE_MAX_MAG;
		end else if (aw_addr == ADDR_ANALOG_MONITOR_ONE_OFS || aw_addr == ADDR_MON2_OFS) begin
			bad_val = ofs < OFS_MIN || ofs > OFS_MAX;
		end
		bad_src = is_virt && !serial_link_src;
	end

	// write channel handshake and response
	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			wr_state <= WS_COLLECT;
			aw_held <= 1'b0;
			w_held <= 1'b0;
			aw_addr <= '0;
			w_data <= '0;
			w_strb <= '0;
			s_axi_awready <= 1'b1;
			s_axi_wready <= 1'b1;
			s_axi_bvalid <= 1'b0;
			s_axi_bresp <= RESP_OKAY;
		end else begin
			case (wr_state)
				WS_COLLECT: begin
					if (s_axi_awvalid && s_axi_awready) begin
						aw_held <= 1'b1;
						aw_addr <= s_axi_awaddr;
						s_axi_awready <= 1'b0;
					end
					if (s_axi_wvalid && s_axi_wready) begin
						w_held <= 1'b1;
						w_data <= s_axi_wdata;
						w_strb <= s_axi_wstrb;
						s_axi_wready <= 1'b0;
					end
					if (wr_fire) begin
						aw_held <= 1'b0;
						w_held <= 1'b0;
						s_axi_bvalid <= 1'b1;
						s_axi_bresp <= unmapped ? RESP_DECERR : (bad_val || bad_src) ? RESP_SLVERR : RESP_OKAY;
						wr_state <= WS_RESP;
					end
				end
				WS_RESP: begin
					if (s_axi_bready) begin
						s_axi_bvalid <= 1'b0;
						s_axi_awready <= 1'b1;
						s_axi_wready <= 1'b1;
						wr_state <= WS_COLLECT;
					end
				end
				default: begin
					wr_state <= WS_COLLECT;
				end
			endcase
		end
	end

	// read channel
	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			s_axi_arready <= 1'b1;
			s_axi_rvalid <= 1'b0;
			s_axi_rdata <= '0;
			s_axi_rresp <= RESP_OKAY;
		end else if (s_axi_arvalid && s_axi_arready) begin
			s_axi_arready <= 1'b0;
			s_axi_rvalid <= 1'b1;
			s_axi_rdata <= reg_view(s_axi_araddr);
			s_axi_rresp <= addr_mapped(s_axi_araddr) ? RESP_OKAY : RESP_DECERR;
		end else if (s_axi_rvalid && s_axi_rready) begin
			s_axi_rvalid <= 1'b0;
			s_axi_arready <= 1'b1;
		end
	end

	// pending and active function codes
	generate
		for (genvar i = 0; i < NUM_LINES; i++) begin : g_line
			always_ff @(posedge ref_clk or negedge rst_n) begin
				if (!rst_n) begin
					pend_code[i] <= code_rst(i);
					act_code[i] <= code_rst(i);
				end else begin
					if (wr_fire && is_code && !bad_val && !bad_src && code_idx == 5'(i)) begin
						pend_code[i] <= merged[CODE_W-1:0];
					end
					if (power_restart) begin
						act_code[i] <= pend_code[i];
					end
				end
			end
			ofms_func_mux u_mux (
				.code(act_code[i]),
				.fvec(fvec),
				.line_val(next_line[i])
			);
		end
	endgenerate

	// function vector with dedicated sources
	always_comb begin
		fvec = gen_status;
		fvec[FC_IN_POSITION] = in_position_flag;
		fvec[FC_POINT_AREA1] = point_area_one;
		fvec[FC_POINT_AREA2] = point_area_two;
		fvec[FC_POS_OT] = positive_overtravel;
		fvec[FC_NEG_OT] = negative_overtravel;
		fvec[FC_HOME_LS] = home_limit_detect;
		fvec[FC_IMM_CONT_PERMIT] = imm_cont_permit;
		fvec[FC_IMM_CONT_DONE] = imm_cont_done;
		fvec[FC_IMM_CHANGE_DONE] = imm_change_done;
	end

	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			line_q <= '0;
		end else begin
			line_q <= next_line;
		end
	end

	assign hw_output_line_one = line_q[0];
	assign hw_output_line_two = line_q[1];
	assign hw_output_line_three = line_q[2];
	assign virt_out = line_q[NUM_LINES-1:NUM_HW];

	// monitor settings, live on write
	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			analog_monitor_one_sel <= ANALOG_MONITOR_ONE_SEL_RST;
			analog_monitor_two_sel <= MON2_SEL_RST;
			analog_monitor_one_scale <= ANALOG_MONITOR_ONE_SCALE_RST;
			mon2_scale <= MON2_SCALE_RST;
			analog_monitor_one_offset <= OFS_RST;
			mon2_offset <= OFS_RST;
			analog_monitor_one_invert <= 1'b0;
			mon2_invert <= 1'b0;
			mon_format <= FMT_RST;
			analog_monitor_one_single <= 1'b0;
			mon2_single <= 1'b0;
		end else if (wr_fire && !bad_val) begin
			if (aw_addr == ADDR_ANALOG_MONITOR_ONE_SEL) begin
				analog_monitor_one_sel <= merged[MON_SEL_W-1:0];
			end else if (aw_addr == ADDR_MON2_SEL) begin
				analog_monitor_two_sel <= merged[MON_SEL_W-1:0];
			end else if (aw_addr == ADDR_ANALOG_MONITOR_ONE_SCALE) begin
				analog_monitor_one_scale <= merged[SCALE_W-1:0];
				analog_monitor_one_invert <= merged[SCALE_W-1];
			end else if (aw_addr == ADDR_MON2_SCALE) begin
				mon2_scale <= merged[SCALE_W-1:0];
				mon2_invert <= merged[SCALE_W-1];
			end else if (aw_addr == ADDR_ANALOG_MONITOR_ONE_OFS) begin
				analog_monitor_one_offset <= merged[OFS_W-1:0];
			end else if (aw_addr == ADDR_MON2_OFS) begin
				mon2_offset <= merged[OFS_W-1:0];
			end else if (aw_addr == ADDR_FORMAT) begin
				mon_format <= merged[FMT_W-1:0];
				analog_monitor_one_single <= merged[FMT_CH1_SINGLE];
				mon2_single <= merged[FMT_CH2_SINGLE];
			end
		end
	end

	// sticky events, set beats write-one clear
	always_comb begin
		next_status = status;
		if (wr_fire && aw_addr == ADDR_STATUS) begin
			next_status = status & ~w_data[STAT_W-1:0];
		end
		if (wr_fire && bad_val) begin
			next_status[STAT_BAD_VALUE] = 1'b1;
		end
		if (wr_fire && bad_src) begin
			next_status[STAT_BAD_SOURCE] = 1'b1;
		end
		if (next_line[NUM_HW-1:0] != line_q[NUM_HW-1:0]) begin
			next_status[STAT_HW_CHANGE] = 1'b1;
		end
	end

	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			status <= STAT_RST;
			mask <= STAT_RST;
			irq <= 1'b0;
		end else begin
			status <= next_status;
			if (wr_fire && aw_addr == ADDR_MASK) begin
				mask <= merged[STAT_W-1:0];
			end
			irq <= |(next_status & mask);
		end
	end

	// first cycle after reset, for checks
	logic started;
	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			started <= 1'b0;
		end else begin
			started <= 1'b1;
		end
	end

	default clocking cb @(posedge ref_clk); endclocking
	default disable iff (!rst_n);

	sequence s_virt_write_local;
		wr_fire && is_virt && !serial_link_src;
	endsequence

	sequence s_refused_answer;
		s_axi_bvalid && s_axi_bresp != RESP_OKAY;
	endsequence

	chk_line_select: assert property (next_line[3] == (code_legal(act_code[3]) ? fvec[act_code[3]] : 1'b0))
		else $error("virtual line does not follow its code");
	chk_hw_defaults: assert property (!started |-> act_code[0] == HW1_CODE_RST && act_code[2] == HW3_CODE_RST)
		else $error("hw line codes not at reset defaults");
	chk_code_hold: assert property (!power_restart |=> act_code[1] == $past(act_code[1]))
		else $error("active code changed without restart");
	chk_restart_load: assert property (power_restart |=> act_code[0] == $past(pend_code[0]))
		else $error("restart did not load pending code");
	chk_virt_source: assert property (s_virt_write_local |=> s_refused_answer ##1 status[STAT_BAD_SOURCE])
		else $error("local virtual code write not refused");
	chk_point_area: assert property (act_code[0] == FC_POINT_AREA2 |=> hw_output_line_one == $past(point_area_two))
		else $error("area two detection not routed");
	chk_imm_flags: assert property (act_code[1] == FC_IMM_CHANGE_DONE |=> hw_output_line_two == $past(imm_change_done))
		else $error("change completion flag not routed");
	chk_overtravel_route: assert property (act_code[2] == FC_NEG_OT |=> hw_output_line_three == $past(negative_overtravel))
		else $error("negative overtravel not routed");
	chk_sel_range: assert property (analog_monitor_two_sel >= MON_SEL_MIN && analog_monitor_two_sel <= MON_SEL_MAX)
		else $error("monitor two selector out of range");
	chk_mon_defaults: assert property (!started |-> analog_monitor_one_sel == ANALOG_MONITOR_ONE_SEL_RST && analog_monitor_two_sel == MON2_SEL_RST)
		else $error("monitor selectors not at defaults");
	chk_format_split: assert property (analog_monitor_one_single == mon_format[FMT_CH1_SINGLE] && mon2_single == mon_format[FMT_CH2_SINGLE])
		else $error("format and single flags disagree");
	chk_offset_range: assert property ($signed(analog_monitor_one_offset) >= OFS_MIN && $signed(mon2_offset) <= OFS_MAX)
		else $error("monitor offset out of range");
	chk_invert_sign: assert property (analog_monitor_one_invert == analog_monitor_one_scale[SCALE_W-1] && mon2_invert == mon2_scale[SCALE_W-1])
		else $error("invert flag disagrees with scale sign");
	chk_sel_immediate: assert property (wr_fire && aw_addr == ADDR_ANALOG_MONITOR_ONE_SEL && !bad_val |=> analog_monitor_one_sel == $past(merged[MON_SEL_W-1:0]))
		else $error("monitor selector write not applied");

endmodule
`default_nettype wire

// *** verification/ofms_host_model.sv ***
// host-side model: status function sources and serial link select
`timescale 1ns/100ps
`default_nettype none
module ofms_host_model import ofms_pkg::*; (
	// clock
	input wire logic ref_clk,
	// status function sources
	output logic [FVEC_W-1:0] gen_status,
	output logic in_position_flag,
	output logic point_area_one,
	output logic point_area_two,
	output logic positive_overtravel,
	output logic negative_overtravel,
	output logic home_limit_detect,
	output logic imm_cont_permit,
	output logic imm_cont_done,
	output logic imm_change_done,
	// link select
	output logic serial_link_src
);
	logic [FVEC_W-1:0] fv = '0;
	logic ser = 1'b0;
	assign gen_status = fv;
	assign in_position_flag = fv[FC_IN_POSITION];
	assign point_area_one = fv[FC_POINT_AREA1];
	assign point_area_two = fv[FC_POINT_AREA2];
	assign positive_overtravel = fv[FC_POS_OT];
	assign negative_overtravel = fv[FC_NEG_OT];
	assign home_limit_detect = fv[FC_HOME_LS];
	assign imm_cont_permit = fv[FC_IMM_CONT_PERMIT];
	assign imm_cont_done = fv[FC_IMM_CONT_DONE];
	assign imm_change_done = fv[FC_IMM_CHANGE_DONE];
	assign serial_link_src = ser;

	task automatic set_func(input logic [6:0] c, input logic v);
		@(posedge ref_clk);
		fv[c] <= v;
	endtask

	task automatic set_link(input logic v);
		@(posedge ref_clk);
		ser <= v;
	endtask
endmodule
`default_nettype wire

// *** verification/tb.sv ***
// self-checking bench for output routing and monitor select
`timescale 1ns/100ps
`default_nettype none
`define CHK(nm, e, g) begin checked++; if ((g) !== (e)) begin err_total++; \
	$display("mismatch %s expected %h seen %h", nm, e, g); end end
module tb import ofms_pkg::*; ;
	logic ref_clk = 1'b0;
	logic rst_n = 1'b0;
	logic [7:0] s_axi_awaddr = '0;
	logic s_axi_awvalid = 1'b0;
	logic [31:0] s_axi_wdata = '0;
	logic [3:0] s_axi_wstrb = 4'hF;
	logic s_axi_wvalid = 1'b0;
	logic s_axi_bready = 1'b0;
	logic [7:0] s_axi_araddr = '0;
	logic s_axi_arvalid = 1'b0;
	logic s_axi_rready = 1'b0;
	logic power_restart = 1'b0;
	logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid, serial_link_src;
	logic [1:0] s_axi_bresp, s_axi_rresp;
	logic [31:0] s_axi_rdata;
	logic [FVEC_W-1:0] gen_status;
	logic in_position_flag, point_area_one, point_area_two, positive_overtravel, negative_overtravel;
	logic home_limit_detect, imm_cont_permit, imm_cont_done, imm_change_done;
	logic hw_output_line_one, hw_output_line_two, hw_output_line_three;
	logic [NUM_VIRT-1:0] virt_out;
	logic [MON_SEL_W-1:0] analog_monitor_one_sel, analog_monitor_two_sel;
	logic [SCALE_W-1:0] analog_monitor_one_scale, mon2_scale;
	logic [OFS_W-1:0] analog_monitor_one_offset, mon2_offset;
	logic analog_monitor_one_invert, analog_monitor_one_single, mon2_invert, mon2_single, irq;
	int err_total = 0;
	int checked = 0;
	int cyc = 0;
	logic [6:0] codes [8] = '{FC_POINT_AREA1, FC_POINT_AREA2, FC_POS_OT, FC_NEG_OT, FC_HOME_LS,
		FC_IMM_CONT_PERMIT, FC_IMM_CONT_DONE, FC_IMM_CHANGE_DONE};

	ofms_top ofms_top_inst (.ref_clk(ref_clk), .rst_n(rst_n), .s_axi_awaddr(s_axi_awaddr),
		.s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready), .s_axi_wdata(s_axi_wdata),
		.s_axi_wstrb(s_axi_wstrb), .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready),
		.s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready),
		.s_axi_araddr(s_axi_araddr), .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready),
		.s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp), .s_axi_rvalid(s_axi_rvalid),
		.s_axi_rready(s_axi_rready), .power_restart(power_restart), .serial_link_src(serial_link_src),
		.gen_status(gen_status), .in_position_flag(in_position_flag), .point_area_one(point_area_one),
		.point_area_two(point_area_two), .positive_overtravel(positive_overtravel),
		.negative_overtravel(negative_overtravel), .home_limit_detect(home_limit_detect),
		.imm_cont_permit(imm_cont_permit), .imm_cont_done(imm_cont_done), .imm_change_done(imm_change_done),
		.hw_output_line_one(hw_output_line_one), .hw_output_line_two(hw_output_line_two),
		.hw_output_line_three(hw_output_line_three), .virt_out(virt_out),
		.analog_monitor_one_sel(analog_monitor_one_sel), .analog_monitor_one_scale(analog_monitor_one_scale), .analog_monitor_one_offset(analog_monitor_one_offset),
		.analog_monitor_one_invert(analog_monitor_one_invert), .analog_monitor_one_single(analog_monitor_one_single), .analog_monitor_two_sel(analog_monitor_two_sel),
		.mon2_scale(mon2_scale), .mon2_offset(mon2_offset), .mon2_invert(mon2_invert),
		.mon2_single(mon2_single), .irq(irq));

	ofms_host_model ofms_host_model_inst (.ref_clk(ref_clk), .gen_status(gen_status),
		.in_position_flag(in_position_flag), .point_area_one(point_area_one), .point_area_two(point_area_two),
		.positive_overtravel(positive_overtravel), .negative_overtravel(negative_overtravel),
		.home_limit_detect(home_limit_detect), .imm_cont_permit(imm_cont_permit),
		.imm_cont_done(imm_cont_done), .imm_change_done(imm_change_done), .serial_link_src(serial_link_src));

	initial begin
		forever #5 ref_clk = ~ref_clk;
	end

	task automatic report_and_stop();
		$display("comparisons %0d mismatches %0d", checked, err_total);
		if (err_total == 0 && checked > 0) begin
			$display("Simulation passed");
		end else begin
			$display("Simulation failed");
		end
		$finish;
	endtask

	always @(posedge ref_clk) begin
		cyc <= cyc + 1;
		if (cyc == 20000) begin
			err_total++;
			report_and_stop();
		end
	end

	task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
		@(posedge ref_clk);
		s_axi_awaddr <= a;
		s_axi_awvalid <= 1'b1;
		s_axi_wdata <= d;
		s_axi_wvalid <= 1'b1;
		s_axi_bready <= 1'b1;
		while (s_axi_bvalid !== 1'b1) begin
			@(posedge ref_clk);
			if (s_axi_awready === 1'b1) s_axi_awvalid <= 1'b0;
			if (s_axi_wready === 1'b1) s_axi_wvalid <= 1'b0;
		end
		`CHK("bresp", er, s_axi_bresp)
		s_axi_bready <= 1'b0;
	endtask

	task automatic rd(input logic [7:0] a, input logic [31:0] e, input logic [1:0] er);
		@(posedge ref_clk);
		s_axi_araddr <= a;
		s_axi_arvalid <= 1'b1;
		s_axi_rready <= 1'b1;
		while (s_axi_rvalid !== 1'b1) begin
			@(posedge ref_clk);
			if (s_axi_arready === 1'b1) s_axi_arvalid <= 1'b0;
		end
		`CHK("rdata", e, s_axi_rdata)
		`CHK("rresp", er, s_axi_rresp)
		s_axi_rready <= 1'b0;
	endtask

	task automatic restart();
		@(posedge ref_clk);
		power_restart <= 1'b1;
		@(posedge ref_clk);
		power_restart <= 1'b0;
	endtask

	task automatic settle();
		repeat (2) @(posedge ref_clk);
	endtask

	initial begin
		repeat (16) @(posedge ref_clk);
		rst_n <= 1'b1;
		rd(ADDR_ANALOG_MONITOR_ONE_SEL, 32'h2, RESP_OKAY);
		rd(ADDR_MON2_SEL, 32'h3, RESP_OKAY);
		rd(ADDR_ANALOG_MONITOR_ONE_SCALE, 32'h46, RESP_OKAY);
		rd(ADDR_FORMAT, 32'h0, RESP_OKAY);
		rd(ADDR_MASK, 32'h0, RESP_OKAY);
		rd(ADDR_CODE_BASE, 32'h0101, RESP_OKAY);
		rd(ADDR_CODE_BASE + 8'h04, 32'h0202, RESP_OKAY);
		rd(ADDR_CODE_BASE + 8'h08, 32'h4C4C, RESP_OKAY);
		`CHK("mon2_scale", 16'h003C, mon2_scale)
		`CHK("sel_two", 5'h03, analog_monitor_two_sel)
		ofms_host_model_inst.set_func(FC_IN_POSITION, 1'b1);
		settle();
		`CHK("lines", 3'b010, {hw_output_line_one, hw_output_line_two, hw_output_line_three})
		ofms_host_model_inst.set_func(FC_IN_POSITION, 1'b0);
		ofms_host_model_inst.set_func(7'h4C, 1'b1);
		settle();
		`CHK("lines", 3'b001, {hw_output_line_one, hw_output_line_two, hw_output_line_three})
		ofms_host_model_inst.set_func(7'h4C, 1'b0);
		wr(ADDR_CODE_BASE, 32'h3, RESP_SLVERR);
		for (int i = 0; i < 8; i++) begin
			wr(ADDR_CODE_BASE, {25'h0, codes[i]}, RESP_OKAY);
			wr(ADDR_CODE_BASE + 8'h04, {25'h0, codes[i]}, RESP_OKAY);
			wr(ADDR_CODE_BASE + 8'h08, {25'h0, codes[i]}, RESP_OKAY);
			ofms_host_model_inst.set_func(codes[i], 1'b1);
			settle();
			`CHK("line_one", 1'b0, hw_output_line_one)
			restart();
			settle();
			`CHK("lines", 3'b111, {hw_output_line_one, hw_output_line_two, hw_output_line_three})
			rd(ADDR_CODE_BASE, {17'h0, codes[i], 1'b0, codes[i]}, RESP_OKAY);
			ofms_host_model_inst.set_func(codes[i], 1'b0);
			settle();
			`CHK("lines", 3'b000, {hw_output_line_one, hw_output_line_two, hw_output_line_three})
		end
		rd(ADDR_STATUS, 32'h5, RESP_OKAY);
		wr(ADDR_STATUS, 32'h7, RESP_OKAY);
		wr(ADDR_MASK, 32'h2, RESP_OKAY);
		wr(ADDR_CODE_BASE + 8'h0C, 32'h12, RESP_SLVERR);
		rd(ADDR_CODE_BASE + 8'h0C, 32'h0, RESP_OKAY);
		settle();
		`CHK("irq", 1'b1, irq)
		wr(ADDR_STATUS, 32'h2, RESP_OKAY);
		settle();
		`CHK("irq", 1'b0, irq)
		ofms_host_model_inst.set_link(1'b1);
		wr(ADDR_CODE_BASE + 8'h0C, 32'h12, RESP_OKAY);
		restart();
		ofms_host_model_inst.set_func(FC_POINT_AREA2, 1'b1);
		settle();
		`CHK("virt_out", 16'h0001, virt_out)
		rd(ADDR_OUT_STATE, 32'h8, RESP_OKAY);
		ofms_host_model_inst.set_func(FC_POINT_AREA2, 1'b0);
		wr(ADDR_MASK, 32'h1, RESP_OKAY);
		wr(ADDR_ANALOG_MONITOR_ONE_SEL, 32'h11, RESP_SLVERR);
		settle();
		`CHK("irq", 1'b1, irq)
		wr(ADDR_STATUS, 32'h1, RESP_OKAY);
		settle();
		`CHK("irq", 1'b0, irq)
		wr(ADDR_ANALOG_MONITOR_ONE_SEL, 32'h10, RESP_OKAY);
		`CHK("sel_one", 5'h10, analog_monitor_one_sel)
		wr(ADDR_ANALOG_MONITOR_ONE_SEL, 32'h0, RESP_SLVERR);
		`CHK("sel_one", 5'h10, analog_monitor_one_sel)
		wr(ADDR_MON2_SEL, 32'h1, RESP_OKAY);
		`CHK("sel_two", 5'h01, analog_monitor_two_sel)
		for (int f = 0; f < 4; f++) begin
			wr(ADDR_FORMAT, f, RESP_OKAY);
			`CHK("single", f[1:0], {mon2_single, analog_monitor_one_single})
		end
		wr(ADDR_ANALOG_MONITOR_ONE_OFS, 32'hFFFFFFCE, RESP_OKAY);
		wr(ADDR_MON2_OFS, 32'h32, RESP_OKAY);
		wr(ADDR_MON2_OFS, 32'h33, RESP_SLVERR);
		wr(ADDR_ANALOG_MONITOR_ONE_OFS, 32'hFFFFFFCD, RESP_SLVERR);
		`CHK("offsets", 16'hCE32, {analog_monitor_one_offset, mon2_offset})
		wr(ADDR_ANALOG_MONITOR_ONE_SCALE, 32'hFFFFFFBA, RESP_OKAY);
		`CHK("scale_inv", 17'h1FFBA, {analog_monitor_one_invert, analog_monitor_one_scale})
		wr(ADDR_ANALOG_MONITOR_ONE_SCALE, 32'h3E8, RESP_OKAY);
		`CHK("scale_inv", 17'h003E8, {analog_monitor_one_invert, analog_monitor_one_scale})
		wr(ADDR_MON2_SCALE, 32'h13, RESP_SLVERR);
		`CHK("scale_two", 17'h0003C, {mon2_invert, mon2_scale})
		wr(ADDR_MON2_SCALE, 32'hFFFFFC18, RESP_OKAY);
		`CHK("scale_two", 17'h1FC18, {mon2_invert, mon2_scale})
		wr(8'h30, 32'h1, RESP_DECERR);
		rd(8'h30, 32'h0, RESP_DECERR);
		rd(8'h02, 32'h0, RESP_DECERR);
		report_and_stop();
	end
endmodule
`default_nettype wire
